// File: core/global_option_pkg.sv
package global_option_pkg;

	// =====================================================================
	// Register map (configuration index values)
	// =====================================================================
	localparam logic [7:0] IDX_TRISTATE   = 8'h25;
	localparam logic [7:0] IDX_ENTRY_LOCK = 8'h26;
	localparam logic [7:0] IDX_RESERVED   = 8'h27;
	localparam logic [7:0] IDX_UART_PRT   = 8'h28;
	localparam logic [7:0] IDX_OUT_LED    = 8'h29;

	// Writable-bit masks; reserved bits stay zero
	localparam logic [7:0] MASK_TRISTATE   = 8'h39;
	localparam logic [7:0] MASK_ENTRY_LOCK = 8'h6F;
	localparam logic [7:0] MASK_UART_PRT   = 8'hF7;
	localparam logic [7:0] MASK_OUT_LED    = 8'hFE;

	// Reset values
	localparam logic [7:0] RST_TRISTATE   = 8'h00;
	localparam logic [7:0] RST_ENTRY_LOCK = 8'h00;
	localparam logic [7:0] RST_UART_PRT   = 8'h00;
	localparam logic [7:0] RST_OUT_LED    = 8'h00;

	// Field positions: tri-state register
	localparam int FLOPPY_FLOAT_BIT  = 0;
	localparam int PRINTER_FLOAT_BIT = 3;
	localparam int SERIAL1_FLOAT_BIT = 4;
	localparam int SERIAL2_FLOAT_BIT = 5;

	// Field positions: entry/lock register
	localparam int SERIAL2_OFF_BIT   = 0;
	localparam int SERIAL1_OFF_BIT   = 1;
	localparam int PRINTER_OFF_BIT   = 2;
	localparam int FLOPPY_OFF_BIT    = 3;
	localparam int LOCK_BIT          = 5;
	localparam int ENTRY_SEL_BIT     = 6;

	// Field positions: uart/printer register
	localparam int PRT_MODE_LSB      = 0;
	localparam int PRT_MODE_MSB      = 2;
	localparam int SERIAL3_OFF_BIT   = 4;
	localparam int SERIAL4_OFF_BIT   = 5;
	localparam int SERIAL5_OFF_BIT   = 6;
	localparam int SERIAL6_OFF_BIT   = 7;

	// Field positions: output type / LED register
	localparam int LED_MODE_LSB      = 1;
	localparam int GPIO3_PP_BIT      = 3;
	localparam int GPIO4_PP_BIT      = 4;
	localparam int GPIO5_PP_BIT      = 5;
	localparam int PIN_FUNC_BIT      = 6;
	localparam int GPIO6_PP_BIT      = 7;

	// Entry and exit keys and port addresses
	localparam logic [7:0] ENTRY_KEY  = 8'h87;
	localparam logic [7:0] EXIT_KEY   = 8'hAA;
	localparam logic [7:0] PORT_LO_IX = 8'h2E;
	localparam logic [7:0] PORT_LO_DT = 8'h2F;
	localparam logic [7:0] PORT_HI_IX = 8'h4E;
	localparam logic [7:0] PORT_HI_DT = 8'h4F;

	// Power LED modes
	typedef enum logic [1:0] {
		LED_FLOAT = 2'h0,
		LED_LOW   = 2'h1,
		LED_1HZ   = 2'h2,
		LED_QHZ   = 2'h3
	} led_mode_t;

	// Timing: clock and LED half periods
	localparam int CLK_HZ        = 40_000_000;
	localparam int LED_1HZ_HALF_MS = 500;
	localparam int LED_QHZ_HALF_MS = 2000;
	// Millisecond tick divider
	localparam int MS_CYCLES     = CLK_HZ / 1000;

endpackage

// File: core/global_option_config_regs.sv
`timescale 1ns/1ps
`default_nettype none

module global_option_config_regs #(
	parameter int MS_CYCLES_P = global_option_pkg::MS_CYCLES
) (
	input  wire logic       mclk,
	input  wire logic       rstn,
	// Host I/O port cycle (one-cycle strobes)
	input  wire logic [7:0] io_addr,
	input  wire logic       io_wr,
	input  wire logic       io_rd,
	input  wire logic [7:0] io_wdata,
	output logic      [7:0] io_rdata,
	output logic            io_rvalid,
	// Power-on straps, caught at reset release
	input  wire logic       strap_entry_hi,
	input  wire logic       strap_floppy_off,
	// Outputs status
	output logic            config_mode,
	output logic            printer_mode_normal,
	// Tri-state enables for interface outputs (high drives)
	output logic            floppy_out_en,
	output logic            printer_out_en,
	output logic            serial1_out_en,
	output logic            serial2_out_en,
	// Legacy IRQ gate inputs from peripheral registers
	input  wire logic       floppy_dor_bit3,
	input  wire logic       printer_device_ctrl_bit4,
	input  wire logic [5:0] serial_handshake_ctrl_bit3,
	output logic            floppy_irq_gate,
	output logic            printer_irq_gate,
	output logic      [5:0] serial_irq_gate,
	// GPIO push-pull selects, groups 3..6
	output logic      [3:0] gpio_push_pull,
	// Shared pin function
	input  wire logic       over_temp_out_n,
	input  wire logic       sys_mgmt_irq_out_n,
	output logic            shared_pin_o,
	// Power LED pin
	output logic            power_led_o,
	output logic            power_led_oe,
	// Floppy / serial6 pin assignment
	output logic            pins_to_floppy
);

	// =====================================================================
	// Registers
	// =====================================================================
	logic [7:0] tristate_reg;     // Interface float controls
	logic [7:0] entry_lock_reg;   // Entry port, lock, legacy request off
	logic [7:0] uart_prt_reg;     // Serial 3..6 irq off, port mode
	logic [7:0] out_led_reg;      // Output types, pin function, LED
	logic [7:0] index_reg;        // Indirect index latch
	logic       key_seen_reg;     // First key write seen
	logic       cfg_mode_reg;     // Configuration mode active
	logic       strap_done_reg;   // Strap capture done
	logic       floppy_off_reg;   // Captured floppy disable strap
	logic [7:0] rdata_reg;        // Read data
	logic       rvalid_reg;       // Read answer pulse

	// =====================================================================
	// Port decode
	// =====================================================================
	wire logic       sel_hi  = entry_lock_reg[global_option_pkg::ENTRY_SEL_BIT];
	wire logic [7:0] ix_port = sel_hi ? global_option_pkg::PORT_HI_IX
	                                   : global_option_pkg::PORT_LO_IX;
	wire logic [7:0] dt_port = sel_hi ? global_option_pkg::PORT_HI_DT
	                                   : global_option_pkg::PORT_LO_DT;
	wire logic       ix_hit  = (io_addr == ix_port);
	wire logic       dt_hit  = (io_addr == dt_port);
	wire logic       key_wr  = io_wr && ix_hit && !cfg_mode_reg &&
	                           (io_wdata == global_option_pkg::ENTRY_KEY);
	wire logic       exit_wr = io_wr && ix_hit && cfg_mode_reg &&
	                           (io_wdata == global_option_pkg::EXIT_KEY);
	// Lock blocks data access; index and exit keep working
	wire logic       locked  = entry_lock_reg[global_option_pkg::LOCK_BIT];
	wire logic       dt_ok   = cfg_mode_reg && dt_hit && !locked;
	wire logic       dt_wr   = dt_ok && io_wr;
	wire logic       dt_rd   = dt_ok && io_rd;

	// Per-register write strobes; the reserved index has none
	wire logic wr_tri  = dt_wr && (index_reg == global_option_pkg::IDX_TRISTATE);
	wire logic wr_lock = dt_wr && (index_reg == global_option_pkg::IDX_ENTRY_LOCK);
	wire logic wr_uart = dt_wr && (index_reg == global_option_pkg::IDX_UART_PRT);
	wire logic wr_led  = dt_wr && (index_reg == global_option_pkg::IDX_OUT_LED);

	// =====================================================================
	// Read mux: unmapped and reserved index read zero
	// =====================================================================
	logic [7:0] rd_mux;
	always_comb begin
		unique case (index_reg)
			global_option_pkg::IDX_TRISTATE:   rd_mux = tristate_reg;
			global_option_pkg::IDX_ENTRY_LOCK: rd_mux = entry_lock_reg;
			global_option_pkg::IDX_UART_PRT:   rd_mux = uart_prt_reg;
			global_option_pkg::IDX_OUT_LED:    rd_mux = out_led_reg;
			default:                           rd_mux = 8'h00;
		endcase
	end

	// =====================================================================
	// Entry sequence and index latch
	// =====================================================================
	// Any other write to the index port breaks a half-done key pair
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			key_seen_reg <= 1'b0;
			cfg_mode_reg <= 1'b0;
		end else if (exit_wr) begin
			key_seen_reg <= 1'b0;
			cfg_mode_reg <= 1'b0;
		end else if (io_wr && ix_hit && !cfg_mode_reg) begin
			key_seen_reg <= key_wr && !key_seen_reg;
			cfg_mode_reg <= key_wr && key_seen_reg;
		end
	end

	// Index only latches while in configuration mode
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			index_reg <= 8'h00;
		end else if (cfg_mode_reg && io_wr && ix_hit && !exit_wr) begin
			index_reg <= io_wdata;
		end
	end

	// =====================================================================
	// Strap capture one clock after reset release
	// =====================================================================
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			strap_done_reg <= 1'b0;
			floppy_off_reg <= 1'b0;
		end else if (!strap_done_reg) begin
			strap_done_reg <= 1'b1;
			floppy_off_reg <= strap_floppy_off;
		end
	end

	// =====================================================================
	// Configuration registers
	// =====================================================================
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			tristate_reg <= global_option_pkg::RST_TRISTATE;
		end else if (wr_tri) begin
			tristate_reg <= io_wdata & global_option_pkg::MASK_TRISTATE;
		end
	end

	// Entry select bit loads from its strap once, then software owns it
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			entry_lock_reg <= global_option_pkg::RST_ENTRY_LOCK;
		end else if (!strap_done_reg) begin
			entry_lock_reg[global_option_pkg::ENTRY_SEL_BIT] <= strap_entry_hi;
		end else if (wr_lock) begin
			entry_lock_reg <= io_wdata & global_option_pkg::MASK_ENTRY_LOCK;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			uart_prt_reg <= global_option_pkg::RST_UART_PRT;
		end else if (wr_uart) begin
			uart_prt_reg <= io_wdata & global_option_pkg::MASK_UART_PRT;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			out_led_reg <= global_option_pkg::RST_OUT_LED;
		end else if (wr_led) begin
			out_led_reg <= io_wdata & global_option_pkg::MASK_OUT_LED;
		end
	end

	// Read answer registered: one cycle after the strobe
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rdata_reg  <= 8'h00;
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= dt_rd;
			if (dt_rd) begin
				rdata_reg <= rd_mux;
			end
		end
	end

	assign io_rdata    = rdata_reg;
	assign io_rvalid   = rvalid_reg;
	assign config_mode = cfg_mode_reg;

	// =====================================================================
	// Interface float and legacy IRQ gating
	// =====================================================================
	assign floppy_out_en  = !tristate_reg[global_option_pkg::FLOPPY_FLOAT_BIT];
	assign printer_out_en = !tristate_reg[global_option_pkg::PRINTER_FLOAT_BIT];
	assign serial1_out_en = !tristate_reg[global_option_pkg::SERIAL1_FLOAT_BIT];
	assign serial2_out_en = !tristate_reg[global_option_pkg::SERIAL2_FLOAT_BIT];

	// Off bit set means the peripheral bit no longer gates: gate forced on
	assign floppy_irq_gate  = floppy_dor_bit3 ||
		entry_lock_reg[global_option_pkg::FLOPPY_OFF_BIT];
	assign printer_irq_gate = printer_device_ctrl_bit4 ||
		entry_lock_reg[global_option_pkg::PRINTER_OFF_BIT];

	// Disable bits for serial 1..6 gathered in channel order
	wire logic [5:0] serial_off = {
		uart_prt_reg[global_option_pkg::SERIAL6_OFF_BIT],
		uart_prt_reg[global_option_pkg::SERIAL5_OFF_BIT],
		uart_prt_reg[global_option_pkg::SERIAL4_OFF_BIT],
		uart_prt_reg[global_option_pkg::SERIAL3_OFF_BIT],
		entry_lock_reg[global_option_pkg::SERIAL2_OFF_BIT],
		entry_lock_reg[global_option_pkg::SERIAL1_OFF_BIT]
	};

	for (genvar i = 0; i < 6; i++) begin : g_serial_gate
		assign serial_irq_gate[i] = serial_handshake_ctrl_bit3[i] ||
			serial_off[i];
	end

	// Only the 0xx codes are defined; 1xx is left to software not to use
	assign printer_mode_normal =
		!uart_prt_reg[global_option_pkg::PRT_MODE_MSB];

	// =====================================================================
	// Output types, pin function, pin assignment
	// =====================================================================
	assign gpio_push_pull = {
		out_led_reg[global_option_pkg::GPIO6_PP_BIT],
		out_led_reg[global_option_pkg::GPIO5_PP_BIT],
		out_led_reg[global_option_pkg::GPIO4_PP_BIT],
		out_led_reg[global_option_pkg::GPIO3_PP_BIT]
	};

	assign shared_pin_o = out_led_reg[global_option_pkg::PIN_FUNC_BIT] ?
		sys_mgmt_irq_out_n : over_temp_out_n;

	assign pins_to_floppy = !floppy_off_reg;

	// =====================================================================
	// Power LED timebase
	// =====================================================================
	// A shared ms tick keeps both blink rates on one small divider
	logic [15:0] ms_cnt_reg;  // Cycles within a millisecond
	logic [10:0] half_cnt_reg; // Milliseconds within a half period
	logic        blink_reg;   // LED square wave phase
	wire logic   ms_tick = (ms_cnt_reg == 16'(MS_CYCLES_P - 1));
	wire logic [1:0] led_field =
		out_led_reg[global_option_pkg::LED_MODE_LSB +: 2];
	wire logic [10:0] half_last = (led_field == global_option_pkg::LED_QHZ) ?
		11'(global_option_pkg::LED_QHZ_HALF_MS - 1) :
		11'(global_option_pkg::LED_1HZ_HALF_MS - 1);

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ms_cnt_reg <= 16'h0000;
		end else begin
			ms_cnt_reg <= ms_tick ? 16'h0000 : ms_cnt_reg + 16'h0001;
		end
	end

	// Counter clears on a mode write so the new rate starts cleanly
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			half_cnt_reg <= 11'h000;
			blink_reg    <= 1'b0;
		end else if (wr_led) begin
			// Phase restarts low so every mode opens from a known level
			half_cnt_reg <= 11'h000;
			blink_reg    <= 1'b0;
		end else if (ms_tick) begin
			if (half_cnt_reg >= half_last) begin
				half_cnt_reg <= 11'h000;
				blink_reg    <= !blink_reg;
			end else begin
				half_cnt_reg <= half_cnt_reg + 11'h001;
			end
		end
	end

	assign power_led_oe = (led_field != global_option_pkg::LED_FLOAT);
	assign power_led_o  = (led_field == global_option_pkg::LED_LOW) ?
		1'b0 : blink_reg;

endmodule

`default_nettype wire

// File: testbench/global_option_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Port checker for the option bank
module global_option_monitor (
	input wire logic       mclk,
	input wire logic       rstn,
	input wire logic [7:0] io_addr,
	input wire logic       io_wr,
	input wire logic       io_rd,
	input wire logic [7:0] io_wdata,
	input wire logic       io_rvalid,
	input wire logic       strap_entry_hi,
	input wire logic       config_mode,
	input wire logic       printer_mode_normal,
	input wire logic       floppy_out_en,
	input wire logic       floppy_dor_bit3,
	input wire logic       printer_device_ctrl_bit4,
	input wire logic [5:0] serial_handshake_ctrl_bit3,
	input wire logic       floppy_irq_gate,
	input wire logic       printer_irq_gate,
	input wire logic [5:0] serial_irq_gate,
	input wire logic [3:0] gpio_push_pull,
	input wire logic       over_temp_out_n,
	input wire logic       sys_mgmt_irq_out_n,
	input wire logic       shared_pin_o,
	input wire logic       power_led_o,
	input wire logic       power_led_oe,
	input wire logic       pins_to_floppy
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	// Index port picked by strap; straps only move while in reset
	wire logic [7:0] kport = strap_entry_hi ? 8'h4E : 8'h2E;
	// =====================================================================
	// Entry key write at the selected index port
	sequence key_wr;
		io_wr && io_wdata == 8'h87 && io_addr == kport;
	endsequence
	a_key_entry: assert property (key_wr ##1 key_wr |=> config_mode)
		else $error("double key write did not enter");
	a_entry_cause: assert property ($rose(config_mode) |->
		$past(io_wr && io_wdata == 8'h87 && io_addr == kport))
		else $error("config mode entered without key");
	a_exit_key: assert property (io_wr && io_wdata == 8'hAA &&
		io_addr == kport |=> !config_mode)
		else $error("exit key ignored");
	a_read_refused: assert property (io_rd && !config_mode |=> !io_rvalid)
		else $error("read answered outside config mode");
	a_read_cause: assert property (io_rvalid |-> $past(io_rd))
		else $error("read valid without read");
	// Off bit only ever forces the gate open, the source still passes
	a_irq_follow: assert property (
		&((~serial_handshake_ctrl_bit3) | serial_irq_gate) &&
		(!floppy_dor_bit3 || floppy_irq_gate) &&
		(!printer_device_ctrl_bit4 || printer_irq_gate))
		else $error("irq gate lost its source bit");
	a_shared_pin: assert property (shared_pin_o == over_temp_out_n ||
		shared_pin_o == sys_mgmt_irq_out_n)
		else $error("shared pin carries neither source");
	a_led_half: assert property ($rose(power_led_o) && power_led_oe |->
		power_led_o[*8])
		else $error("LED high phase too short");
	a_strap_hold: assert property (rstn && $past(rstn) |=>
		$stable(pins_to_floppy))
		else $error("pin assignment moved after reset");
	a_cfg_by_write: assert property ($changed({gpio_push_pull,
		floppy_out_en, printer_mode_normal}) |-> $past(io_wr))
		else $error("option output moved without a write");
endmodule
bind global_option_config_regs global_option_monitor u_mon (
	.mclk, .rstn, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rvalid,
	.strap_entry_hi, .config_mode, .printer_mode_normal, .floppy_out_en,
	.floppy_dor_bit3, .printer_device_ctrl_bit4, .serial_handshake_ctrl_bit3,
	.floppy_irq_gate, .printer_irq_gate, .serial_irq_gate, .gpio_push_pull,
	.over_temp_out_n, .sys_mgmt_irq_out_n, .shared_pin_o, .power_led_o,
	.power_led_oe, .pins_to_floppy
);
`default_nettype wire

// File: testbench/global_option_config_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module global_option_config_regs_bench;
	// =====================================================================
	// Stimulus and observed pins
	localparam int MS = 4;	// Short tick so blink phases stay brief
	logic       mclk = 1'b0, rstn = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
	logic [7:0] io_addr = 8'h00, io_wdata = 8'h00;
	logic       hi = 1'b0, fd_off = 1'b0;	// Power-on straps
	logic       dor = 1'b0, printer_device_ctrl = 1'b0, ovt = 1'b0, smi = 1'b1;
	logic [5:0] serial_handshake_ctrl = 6'h00;	// Handshake bits, serial1..6
	logic [7:0] rdata;
	logic [5:0] sgate;
	logic [3:0] pp;
	logic       rvalid, cmode, pnorm, f_en, p_en, s1_en, s2_en;
	logic       fgate, pgate, shp, led, led_oe, to_fd;
	int         n_errors = 0, n_tests = 0, h;
	// Index port follows the entry strap
	wire [7:0]  ix = hi ? 8'h4E : 8'h2E;
	logic [7:0] idx [6] = '{8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h30};
	logic [7:0] xm [5] = '{8'h39, 8'h0F, 8'h00, 8'hF3, 8'hFE};
	// Write values: lock stays off, port mode keeps its top bit clear
	logic [7:0] wv [5] = '{8'hFF, 8'h0F, 8'hFF, 8'hFB, 8'hFF};
	always #12.5 mclk = ~mclk;
	global_option_config_regs #(.MS_CYCLES_P(MS)) dut (
		.mclk(mclk), .rstn(rstn), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(rdata),
		.io_rvalid(rvalid), .strap_entry_hi(hi), .strap_floppy_off(fd_off),
		.config_mode(cmode), .printer_mode_normal(pnorm),
		.floppy_out_en(f_en), .printer_out_en(p_en),
		.serial1_out_en(s1_en), .serial2_out_en(s2_en),
		.floppy_dor_bit3(dor), .printer_device_ctrl_bit4(printer_device_ctrl),
		.serial_handshake_ctrl_bit3(serial_handshake_ctrl), .floppy_irq_gate(fgate),
		.printer_irq_gate(pgate), .serial_irq_gate(sgate),
		.gpio_push_pull(pp), .over_temp_out_n(ovt),
		.sys_mgmt_irq_out_n(smi), .shared_pin_o(shp), .power_led_o(led),
		.power_led_oe(led_oe), .pins_to_floppy(to_fd)
	);
	// =====================================================================
	// Access tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Strobe stays up so key writes can run back to back
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		io_addr <= a;
		io_wdata <= d;
		io_wr <= 1'b1;
		@(posedge mclk);
	endtask
	// Answer is looked at just after the edge that registers it
	task automatic rd(input logic [7:0] a, input logic v, input logic [7:0] e);
		io_wr <= 1'b0;
		io_addr <= a;
		io_rd <= 1'b1;
		@(posedge mclk);
		io_rd <= 1'b0;
		#1;
		chk({7'h00, rvalid}, {7'h00, v});
		if (v) begin
			chk(rdata, e);
		end
	endtask
	task automatic idle(input int n);
		io_wr <= 1'b0;
		io_rd <= 1'b0;
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic cfg_wr(input logic [7:0] i, input logic [7:0] d);
		wr(ix, i);
		wr(ix + 8'h01, d);
	endtask
	task automatic cfg_rd(input logic [7:0] i, input logic v, input logic [7:0] e);
		wr(ix, i);
		rd(ix + 8'h01, v, e);
	endtask
	task automatic enter();
		wr(ix, 8'h87);
		wr(ix, 8'h87);
		idle(1);
	endtask
	task automatic do_reset();
		rstn <= 1'b0;
		repeat (8) @(posedge mclk);
		rstn <= 1'b1;
		repeat (2) @(posedge mclk);
		#1;
	endtask
	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// =====================================================================
	// Test sequence
	initial begin
		do_reset();
		chk({2'h0, f_en, p_en, s1_en, s2_en, led_oe, to_fd}, 8'h3D);
		rd(ix + 8'h01, 1'b0, 8'h00);
		enter();
		chk({7'h00, cmode}, 8'h01);
		for (int i = 0; i < 6; i++) begin
			cfg_rd(idx[i], 1'b1, 8'h00);
		end
		$display("reset values test done");
		// All ones into every register except entry/lock (0F) and uart/printer (FB); reserved bits must drop
		for (int i = 0; i < 5; i++) begin
			cfg_wr(idx[i], wv[i]);
			cfg_rd(idx[i], 1'b1, xm[i]);
		end
		idle(1);
		chk({pnorm, f_en, p_en, s1_en, s2_en, fgate, pgate, shp}, 8'h87);
		chk({2'h0, sgate}, 8'h3F);
		chk({4'h0, pp}, 8'h0F);
		for (int i = 0; i < 5; i++) begin
			cfg_wr(idx[i], 8'h00);
		end
		dor <= 1'b1;
		serial_handshake_ctrl <= 6'h15;
		ovt <= 1'b1;
		smi <= 1'b0;
		idle(1);
		chk({pnorm, f_en, p_en, s1_en, s2_en, fgate, pgate, shp}, 8'hFD);
		chk({2'h0, sgate}, 8'h15);
		chk({4'h0, pp}, 8'h00);
		$display("field test done");
		// Every LED mode; blink checked mid-phase, low first
		for (int m = 0; m < 4; m++) begin
			cfg_wr(8'h29, {5'h00, m[1:0], 1'b0});
			idle(1);
			chk({7'h00, led_oe}, {7'h00, m != 0});
			if (m > 0) begin
				chk({7'h00, led}, 8'h00);
			end
			if (m > 1) begin
				h = ((m == 2) ? 500 : 2000) * MS;
				idle(h / 2);
				chk({7'h00, led}, 8'h00);
				idle(h);
				chk({7'h00, led}, 8'h01);
			end
		end
		$display("LED test done");
		// Lock shuts the data port until the next reset
		cfg_wr(8'h26, 8'h20);
		cfg_rd(8'h26, 1'b0, 8'h00);
		cfg_wr(8'h25, 8'h39);
		idle(1);
		chk({4'h0, f_en, p_en, s1_en, s2_en}, 8'h0F);
		$display("lock test done");
		// Other straps: high entry port, floppy pins given away
		hi <= 1'b1;
		fd_off <= 1'b1;
		do_reset();
		chk({7'h00, to_fd}, 8'h00);
		wr(8'h2E, 8'h87);
		wr(8'h2E, 8'h87);
		wr(ix, 8'h87);
		wr(ix, 8'h29);
		wr(ix, 8'h87);
		idle(1);
		chk({7'h00, cmode}, 8'h00);
		enter();
		chk({7'h00, cmode}, 8'h01);
		cfg_rd(8'h26, 1'b1, 8'h40);
		wr(ix, 8'hAA);
		idle(1);
		chk({7'h00, cmode}, 8'h00);
		rd(ix + 8'h01, 1'b0, 8'h00);
		$display("entry port test done");
		test_done();
	end
	// Run needs about 15000 cycles; reaching 40000 means a hang
	initial begin
		#1_000_000;
		n_errors++;
		$display("watchdog expired");
		test_done();
	end
endmodule
`default_nettype wire
